// *** rtl/rxpic_pkg.sv ***
// Shared constants and types for the receive-port interrupt control block
package rxpic_pkg;

	// ------------------------------------------------------------
	// Port count and register offsets
	// ------------------------------------------------------------
	localparam int         NUM_PORTS      = 4;
	localparam logic [7:0] ADDR_PORT_SEL  = 8'h4C;
	localparam logic [7:0] ADDR_STS_ONE   = 8'h4D;
	localparam logic [7:0] ADDR_STS_TWO   = 8'h4E;
	localparam logic [7:0] ADDR_FILT_STS  = 8'hD7;
	localparam logic [7:0] ADDR_EN_HI     = 8'hD8;
	localparam logic [7:0] ADDR_EN_LO     = 8'hD9;
	localparam logic [7:0] ADDR_PEND_HI   = 8'hDA;
	localparam logic [7:0] ADDR_PEND_LO   = 8'hDB;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int HI_ENC   = 2;
	localparam int HI_SEQ   = 1;
	localparam int HI_CRC   = 0;
	localparam int LO_LEN   = 6;
	localparam int LO_CNT   = 5;
	localparam int LO_BUF   = 4;
	localparam int LO_PAR   = 2;
	localparam int LO_PASS  = 1;
	localparam int LO_LOCK  = 0;
	localparam int FILT_ERR = 6;
	localparam int DDLY_W   = 6;
	localparam int PSEL_WM_LSB = 0;
	localparam int PSEL_RP_LSB = 4;

	// ------------------------------------------------------------
	// Masks and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] HI_MASK      = 8'h07;
	localparam logic [7:0] LO_MASK      = 8'h77;
	localparam logic [7:0] CLR_ONE_HI   = 8'h03;
	localparam logic [7:0] CLR_ONE_LO   = 8'h07;
	localparam logic [7:0] CLR_TWO_HI   = 8'h04;
	localparam logic [7:0] CLR_TWO_LO   = 8'h70;
	localparam logic [7:0] PSEL_MASK    = 8'h3F;
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam logic [7:0] PSEL_RST     = 8'h01;
	localparam logic [3:0] BITS_FULL    = 4'h8;

	// Serial target states
	typedef enum logic [2:0] {
		I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_WR_BYTE, I2C_WR_ACK, I2C_RD_BYTE, I2C_RD_ACK
	} rxpic_i2c_state_type;

endpackage : rxpic_pkg

// *** rtl/rxpic_port_bank.sv ***
// Enable, pending and filter error state of one receive port
`timescale 1ns/1ns
module rxpic_port_bank
	import rxpic_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       en_hi_we,
	input  wire logic       en_lo_we,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] ev_hi,
	input  wire logic [7:0] ev_lo,
	input  wire logic [7:0] clr_hi,
	input  wire logic [7:0] clr_lo,
	input  wire logic       filt_invalid,
	input  wire logic       filt_clr,
	output logic      [7:0] en_hi_q,
	output logic      [7:0] en_lo_q,
	output logic      [7:0] pend_hi_q,
	output logic      [7:0] pend_lo_q,
	output logic            filt_err_q,
	output logic            pend_active
);

	// Enable registers, reserved bits stay zero
	always_ff @(posedge clock) begin
		if (!rstn) begin
			en_hi_q <= RST_ZERO;
			en_lo_q <= RST_ZERO;
		end else begin
			if (en_hi_we)
				en_hi_q <= wdata & HI_MASK;
			if (en_lo_we)
				en_lo_q <= wdata & LO_MASK;
		end
	end

	// Gated events set pending bits; a set in the clear cycle wins
	always_ff @(posedge clock) begin
		if (!rstn) begin
			pend_hi_q <= RST_ZERO;
			pend_lo_q <= RST_ZERO;
		end else begin
			pend_hi_q <= ((pend_hi_q & ~clr_hi) | (ev_hi & en_hi_q)) & HI_MASK;
			pend_lo_q <= ((pend_lo_q & ~clr_lo) | (ev_lo & en_lo_q)) & LO_MASK;
		end
	end

	// Sticky filter error, cleared by its own read
	always_ff @(posedge clock) begin
		if (!rstn)
			filt_err_q <= 1'b0;
		else
			filt_err_q <= (filt_err_q & ~filt_clr) | filt_invalid;
	end

	// Pending and still enabled
	assign pend_active = |((pend_hi_q & en_hi_q) | (pend_lo_q & en_lo_q));

endmodule : rxpic_port_bank

// *** rtl/rxpic_sync2.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module rxpic_sync2 #(
	parameter int          WIDTH = 1,
	parameter logic        INIT  = 1'b1
) (
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge clock) begin
		if (!rstn) begin
			meta_q   <= {WIDTH{INIT}};
			sync_out <= {WIDTH{INIT}};
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : rxpic_sync2

// *** rtl/rxpic_top.sv ***
// Receive-port interrupt control with its serial register target
`timescale 1ns/1ns
module rxpic_top
	import rxpic_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h30  // Arbitrary target address
) (
	input  wire logic                             clock,
	input  wire logic                             rstn,
	input  wire logic                             scl_in,
	input  wire logic                             sda_in,
	output logic                                  sda_out_q,
	output logic                                  sda_oe_n_q,
	input  wire logic [NUM_PORTS-1:0]             ev_link_encoding_error,
	input  wire logic [NUM_PORTS-1:0]             ev_ctrl_chan_sequence_error,
	input  wire logic [NUM_PORTS-1:0]             ev_ctrl_chan_crc_error,
	input  wire logic [NUM_PORTS-1:0]             ev_line_length_change,
	input  wire logic [NUM_PORTS-1:0]             ev_line_count_change,
	input  wire logic [NUM_PORTS-1:0]             ev_rx_buffer_overflow,
	input  wire logic [NUM_PORTS-1:0]             ev_link_parity_error,
	input  wire logic [NUM_PORTS-1:0]             ev_port_valid_change,
	input  wire logic [NUM_PORTS-1:0]             ev_lock_change,
	input  wire logic [NUM_PORTS-1:0]             filter_meas_invalid,
	input  wire logic [NUM_PORTS-1:0][DDLY_W-1:0] filter_data_delay,
	input  wire logic [NUM_PORTS-1:0][7:0]        rx_port_status_one,
	input  wire logic [NUM_PORTS-1:0][7:0]        rx_port_status_two,
	output logic                                  irq_q
);

	// ------------------------------------------------------------
	// Pin synchronisation and bus condition detection
	// ------------------------------------------------------------
	logic [1:0] pins_s;
	logic       scl_s;
	logic       sda_s;
	logic       scl_d_q;
	logic       sda_d_q;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_cond;
	logic       stop_cond;

	rxpic_sync2 #(
		.WIDTH    (2),
		.INIT     (1'b1)
	) rxpic_sync2_i (
		.clock    (clock),
		.rstn     (rstn),
		.async_in ({scl_in, sda_in}),
		.sync_out (pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// Delayed copies for edge detection
	always_ff @(posedge clock) begin
		if (!rstn) begin
			scl_d_q <= 1'b1;
			sda_d_q <= 1'b1;
		end else begin
			scl_d_q <= scl_s;
			sda_d_q <= sda_s;
		end
	end

	assign scl_rise   = scl_s & ~scl_d_q;
	assign scl_fall   = ~scl_s & scl_d_q;
	assign start_cond = scl_s & scl_d_q & sda_d_q & ~sda_s;
	assign stop_cond  = scl_s & scl_d_q & ~sda_d_q & sda_s;

	// ------------------------------------------------------------
	// Serial target state machine
	// ------------------------------------------------------------
	rxpic_i2c_state_type state_q;
	logic [3:0]          bit_cnt_q;
	logic [7:0]          shift_q;
	logic [7:0]          tx_q;
	logic [7:0]          ptr_q;
	logic                rnw_q;
	logic                first_q;
	logic                nack_q;
	logic                wr_stb;
	logic                rd_load;
	logic [7:0]          rd_data;

	// Byte accepted from the bus, and byte fetched for sending
	assign wr_stb  = (state_q == I2C_WR_BYTE) && scl_fall && (bit_cnt_q == BITS_FULL) && !first_q;
	assign rd_load = scl_fall && (((state_q == I2C_ADDR_ACK) && rnw_q)
		|| ((state_q == I2C_RD_ACK) && !nack_q));

	// Bus sequencing: address, pointer, data with auto increment
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_q    <= I2C_IDLE;
			bit_cnt_q  <= 4'h0;
			shift_q    <= RST_ZERO;
			tx_q       <= RST_ZERO;
			ptr_q      <= RST_ZERO;
			rnw_q      <= 1'b0;
			first_q    <= 1'b0;
			nack_q     <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (start_cond) begin
			state_q    <= I2C_ADDR;
			bit_cnt_q  <= 4'h0;
			sda_oe_n_q <= 1'b1;
		end else if (stop_cond) begin
			state_q    <= I2C_IDLE;
			sda_oe_n_q <= 1'b1;
		end else if (scl_rise) begin
			shift_q   <= {shift_q[6:0], sda_s};
			bit_cnt_q <= bit_cnt_q + 4'h1;
			if (state_q == I2C_RD_ACK)
				nack_q <= sda_s;
		end else if (scl_fall) begin
			case (state_q)
				I2C_ADDR: begin
					if (bit_cnt_q == BITS_FULL) begin
						if (shift_q[7:1] == DEV_ADDR) begin
							rnw_q      <= shift_q[0];
							sda_oe_n_q <= 1'b0;
							state_q    <= I2C_ADDR_ACK;
						end else begin
							state_q    <= I2C_IDLE;
						end
					end
				end
				I2C_ADDR_ACK: begin
					bit_cnt_q <= 4'h0;
					if (rnw_q) begin
						tx_q       <= rd_data;
						sda_oe_n_q <= rd_data[7];
						ptr_q      <= ptr_q + 8'h01;
						state_q    <= I2C_RD_BYTE;
					end else begin
						first_q    <= 1'b1;
						sda_oe_n_q <= 1'b1;
						state_q    <= I2C_WR_BYTE;
					end
				end
				I2C_WR_BYTE: begin
					if (bit_cnt_q == BITS_FULL) begin
						sda_oe_n_q <= 1'b0;
						state_q    <= I2C_WR_ACK;
						first_q    <= 1'b0;
						ptr_q      <= first_q ? shift_q : ptr_q + 8'h01;
					end
				end
				I2C_WR_ACK: begin
					sda_oe_n_q <= 1'b1;
					bit_cnt_q  <= 4'h0;
					state_q    <= I2C_WR_BYTE;
				end
				I2C_RD_BYTE: begin
					if (bit_cnt_q == BITS_FULL) begin
						sda_oe_n_q <= 1'b1;
						state_q    <= I2C_RD_ACK;
					end else begin
						tx_q       <= {tx_q[6:0], 1'b0};
						sda_oe_n_q <= tx_q[6];
					end
				end
				I2C_RD_ACK: begin
					bit_cnt_q <= 4'h0;
					if (!nack_q) begin
						tx_q       <= rd_data;
						sda_oe_n_q <= rd_data[7];
						ptr_q      <= ptr_q + 8'h01;
						state_q    <= I2C_RD_BYTE;
					end else begin
						state_q    <= I2C_IDLE;
					end
				end
				default: begin
					sda_oe_n_q <= 1'b1;
				end
			endcase
		end
	end

	// Open-drain data pin only ever pulls low
	always_ff @(posedge clock) begin
		if (!rstn)
			sda_out_q <= 1'b0;
		else
			sda_out_q <= 1'b0;
	end

	// ------------------------------------------------------------
	// Port select register
	// ------------------------------------------------------------
	logic [7:0] port_sel_q;
	logic [1:0] rd_port;

	// Write mask in low nibble, read port above it
	always_ff @(posedge clock) begin
		if (!rstn)
			port_sel_q <= PSEL_RST;
		else if (wr_stb && (ptr_q == ADDR_PORT_SEL))
			port_sel_q <= shift_q & PSEL_MASK;
	end

	assign rd_port = port_sel_q[PSEL_RP_LSB +: 2];

	// ------------------------------------------------------------
	// Per-port banks
	// ------------------------------------------------------------
	logic [NUM_PORTS-1:0][7:0] en_hi;
	logic [NUM_PORTS-1:0][7:0] en_lo;
	logic [NUM_PORTS-1:0][7:0] pend_hi;
	logic [NUM_PORTS-1:0][7:0] pend_lo;
	logic [NUM_PORTS-1:0]      filt_err;
	logic [NUM_PORTS-1:0]      pend_active;

	generate
		for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
			logic       sel_wr;
			logic       sel_rd;
			logic       rd_one;
			logic       rd_two;
			logic [7:0] ev_hi;
			logic [7:0] ev_lo;

			assign sel_wr = wr_stb && port_sel_q[PSEL_WM_LSB + p];
			assign sel_rd = rd_load && (rd_port == 2'(p));
			assign rd_one = sel_rd && (ptr_q == ADDR_STS_ONE);
			assign rd_two = sel_rd && (ptr_q == ADDR_STS_TWO);

			// Event bits placed at their status positions
			always_comb begin
				ev_hi          = RST_ZERO;
				ev_lo          = RST_ZERO;
				ev_hi[HI_ENC]  = ev_link_encoding_error[p];
				ev_hi[HI_SEQ]  = ev_ctrl_chan_sequence_error[p];
				ev_hi[HI_CRC]  = ev_ctrl_chan_crc_error[p];
				ev_lo[LO_LEN]  = ev_line_length_change[p];
				ev_lo[LO_CNT]  = ev_line_count_change[p];
				ev_lo[LO_BUF]  = ev_rx_buffer_overflow[p];
				ev_lo[LO_PAR]  = ev_link_parity_error[p];
				ev_lo[LO_PASS] = ev_port_valid_change[p];
				ev_lo[LO_LOCK] = ev_lock_change[p];
			end

			rxpic_port_bank rxpic_port_bank_i (
				.clock        (clock),
				.rstn         (rstn),
				.en_hi_we     (sel_wr && (ptr_q == ADDR_EN_HI)),
				.en_lo_we     (sel_wr && (ptr_q == ADDR_EN_LO)),
				.wdata        (shift_q),
				.ev_hi        (ev_hi),
				.ev_lo        (ev_lo),
				// Status one read clears 14/15/17, status two read clears 13/16
				.clr_hi       ((rd_one ? CLR_ONE_HI : RST_ZERO)
					| (rd_two ? CLR_TWO_HI : RST_ZERO)),
				.clr_lo       ((rd_one ? CLR_ONE_LO : RST_ZERO)
					| (rd_two ? CLR_TWO_LO : RST_ZERO)),
				.filt_invalid (filter_meas_invalid[p]),
				.filt_clr     (sel_rd && (ptr_q == ADDR_FILT_STS)),
				.en_hi_q      (en_hi[p]),
				.en_lo_q      (en_lo[p]),
				.pend_hi_q    (pend_hi[p]),
				.pend_lo_q    (pend_lo[p]),
				.filt_err_q   (filt_err[p]),
				.pend_active  (pend_active[p])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Read data selection
	// ------------------------------------------------------------
	always_comb begin
		rd_data = RST_ZERO;
		case (ptr_q)
			ADDR_PORT_SEL: rd_data = port_sel_q;
			ADDR_STS_ONE:  rd_data = rx_port_status_one[rd_port];
			ADDR_STS_TWO:  rd_data = rx_port_status_two[rd_port];
			ADDR_FILT_STS: begin
				rd_data[FILT_ERR]     = filt_err[rd_port];
				rd_data[DDLY_W-1:0]   = filter_data_delay[rd_port];
			end
			ADDR_EN_HI:    rd_data = en_hi[rd_port];
			ADDR_EN_LO:    rd_data = en_lo[rd_port];
			ADDR_PEND_HI:  rd_data = pend_hi[rd_port];
			ADDR_PEND_LO:  rd_data = pend_lo[rd_port];
			default:       rd_data = RST_ZERO;
		endcase
	end

	// ------------------------------------------------------------
	// Interrupt output
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rstn)
			irq_q <= 1'b0;
		else
			irq_q <= |pend_active;
	end

endmodule : rxpic_top

// *** tb/rxpic_host.sv ***
// Serial bus host that reaches the block's registers
`timescale 1ns/1ns
module rxpic_host #(
	parameter logic [6:0] DEV = 7'h30,
	parameter int         H   = 8
) (
	input  wire logic clock,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_drv
);
	// Bus idles released, clock standing high
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic tick();
		repeat (H) @(negedge clock);
	endtask : tick
	task automatic start();
		@(negedge clock);
		sda_drv = 1'b1;
		tick();
		scl = 1'b1;
		tick();
		sda_drv = 1'b0;
		tick();
		scl = 1'b0;
	endtask : start
	task automatic stop();
		@(negedge clock);
		sda_drv = 1'b0;
		tick();
		scl = 1'b1;
		tick();
		sda_drv = 1'b1;
		tick();
	endtask : stop
	task automatic put(input logic b);
		@(negedge clock);
		sda_drv = b;
		tick();
		scl = 1'b1;
		tick();
		scl = 1'b0;
	endtask : put
	task automatic get(output logic b);
		@(negedge clock);
		sda_drv = 1'b1;
		tick();
		scl = 1'b1;
		tick();
		b = sda;
		scl = 1'b0;
	endtask : get
	task automatic xfer_out(input logic [7:0] d, output logic ok);
		logic n;
		for (int i = 7; i >= 0; i--) put(d[i]);
		get(n);
		ok = !n;
	endtask : xfer_out
	task automatic xfer_in(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) get(d[i]);
		put(last);
	endtask : xfer_in
	// Pointer byte then one data byte
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic o1, o2, o3;
		start();
		xfer_out({DEV, 1'b0}, o1);
		xfer_out(a, o2);
		xfer_out(d, o3);
		stop();
		ok = o1 & o2 & o3;
	endtask : wr
	// Pointer byte, repeated start, one byte ended by no-acknowledge
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic o1, o2, o3;
		start();
		xfer_out({DEV, 1'b0}, o1);
		xfer_out(a, o2);
		start();
		xfer_out({DEV, 1'b1}, o3);
		xfer_in(1'b1, d);
		stop();
		ok = o1 & o2 & o3;
	endtask : rd
endmodule : rxpic_host

// *** tb/rxpic_props.sv ***
// Pin-level checker for the receive-port interrupt control block
`timescale 1ns/1ns
module rxpic_props
	import rxpic_pkg::*;
(
	input wire logic                 clock,
	input wire logic                 rstn,
	input wire logic                 scl_in,
	input wire logic                 sda_out_q,
	input wire logic                 sda_oe_n_q,
	input wire logic [NUM_PORTS-1:0] ev_link_encoding_error,
	input wire logic [NUM_PORTS-1:0] ev_ctrl_chan_sequence_error,
	input wire logic [NUM_PORTS-1:0] ev_ctrl_chan_crc_error,
	input wire logic [NUM_PORTS-1:0] ev_line_length_change,
	input wire logic [NUM_PORTS-1:0] ev_line_count_change,
	input wire logic [NUM_PORTS-1:0] ev_rx_buffer_overflow,
	input wire logic [NUM_PORTS-1:0] ev_link_parity_error,
	input wire logic [NUM_PORTS-1:0] ev_port_valid_change,
	input wire logic [NUM_PORTS-1:0] ev_lock_change,
	input wire logic                 irq_q
);
	logic       scl_d_q;
	logic [3:0] since_q;
	logic       any_ev;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	// Any link event on any port
	assign any_ev = |{ev_link_encoding_error, ev_ctrl_chan_sequence_error, ev_ctrl_chan_crc_error,
		ev_line_length_change, ev_line_count_change, ev_rx_buffer_overflow,
		ev_link_parity_error, ev_port_valid_change, ev_lock_change};

	// Cycles since the serial clock pin last fell, saturating
	always_ff @(posedge clock) begin
		scl_d_q <= rstn ? scl_in : 1'b1;
		if (!rstn) begin
			since_q <= 4'hF;
		end else if (scl_d_q && !scl_in) begin
			since_q <= 4'h0;
		end else if (since_q != 4'hF) begin
			since_q <= since_q + 4'h1;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_reset_out;
		disable iff (1'b0) !rstn |=> !irq_q && sda_oe_n_q && !sda_out_q;
	endproperty
	a_reset_out: assert property (p_reset_out)
		else $error("outputs not idle after reset");
	property p_sda_zero;
		sda_out_q == 1'b0;
	endproperty
	a_sda_zero: assert property (p_sda_zero)
		else $error("data pin value not zero");
	property p_irq_rise;
		$rose(irq_q) |-> $past(any_ev, 2) || since_q <= 4'hC;
	endproperty
	a_irq_rise: assert property (p_irq_rise)
		else $error("interrupt rose without a cause");
	property p_irq_fall;
		$fell(irq_q) |-> since_q <= 4'hC;
	endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("interrupt fell without a register access");
	property p_ack_low;
		$fell(sda_oe_n_q) |-> !scl_in;
	endproperty
	a_ack_low: assert property (p_ack_low)
		else $error("data pin pulled while clock high");
	property p_ack_delay;
		$fell(sda_oe_n_q) |-> since_q >= 4'h1 && since_q <= 4'h9;
	endproperty
	a_ack_delay: assert property (p_ack_delay)
		else $error("data pin pulled late");
	property p_rel_low;
		$rose(sda_oe_n_q) |-> !scl_in;
	endproperty
	a_rel_low: assert property (p_rel_low)
		else $error("data pin released while clock high");
	property p_rel_delay;
		$rose(sda_oe_n_q) |-> since_q >= 4'h1 && since_q <= 4'h9;
	endproperty
	a_rel_delay: assert property (p_rel_delay)
		else $error("data pin released late");
endmodule : rxpic_props

bind rxpic_top rxpic_props rxpic_props_i (.clock, .rstn, .scl_in, .sda_out_q, .sda_oe_n_q,
	.ev_link_encoding_error, .ev_ctrl_chan_sequence_error, .ev_ctrl_chan_crc_error,
	.ev_line_length_change, .ev_line_count_change, .ev_rx_buffer_overflow,
	.ev_link_parity_error, .ev_port_valid_change, .ev_lock_change, .irq_q);

// *** tb/tb_rx_port_interrupt_control.sv ***
// Self-checking bench for the receive-port interrupt control block
`timescale 1ns/1ns
module tb_rx_port_interrupt_control
	import rxpic_pkg::*;
;
	// Per event kind k: high register, field position, cleared by status two
	localparam logic [8:0]  EV_HI  = 9'h007;
	localparam logic [26:0] EV_BIT = {3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h0, 3'h1, 3'h2};
	localparam logic [8:0]  EV_TWO = 9'h039;
	logic                             clock, rstn, scl, sda_drv, sda, sda_out_q, sda_oe_n_q;
	logic                             irq_q, ok;
	logic [NUM_PORTS-1:0]             ev [9];
	logic [NUM_PORTS-1:0]             f_inv;
	logic [NUM_PORTS-1:0][DDLY_W-1:0] f_dly;
	logic [NUM_PORTS-1:0][7:0]        st1, st2;
	logic [7:0]                       rv, er, pr, m;
	int                               p, bad_count, samples_checked;

	// Pulled-up data wire shared by host and block
	assign sda = sda_drv & sda_oe_n_q;

	rxpic_top rxpic_top_i (.clock, .rstn, .scl_in(scl), .sda_in(sda), .sda_out_q, .sda_oe_n_q,
		.ev_link_encoding_error(ev[0]), .ev_ctrl_chan_sequence_error(ev[1]),
		.ev_ctrl_chan_crc_error(ev[2]), .ev_line_length_change(ev[3]),
		.ev_line_count_change(ev[4]), .ev_rx_buffer_overflow(ev[5]),
		.ev_link_parity_error(ev[6]), .ev_port_valid_change(ev[7]), .ev_lock_change(ev[8]),
		.filter_meas_invalid(f_inv), .filter_data_delay(f_dly), .rx_port_status_one(st1),
		.rx_port_status_two(st2), .irq_q);
	rxpic_host rxpic_host_i (.clock, .sda, .scl, .sda_drv);

	// 125 MHz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp8
	task automatic cmp1(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask : cmp1
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		rxpic_host_i.wr(a, d, ok);
		cmp1("write ack", 1'b1, ok);
	endtask : wr
	task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
		rxpic_host_i.rd(a, rv, ok);
		cmp1("read ack", 1'b1, ok);
		cmp8(what, exp, rv);
	endtask : rdc
	task automatic pulse(input int k, input logic [3:0] pm);
		@(negedge clock);
		ev[k] = pm;
		@(negedge clock);
		ev[k] = '0;
		repeat (3) @(negedge clock);
	endtask : pulse
	task automatic test_done();
		$display("Comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done

	// Hang guard
	initial begin
		repeat (90000) @(posedge clock);
		cmp1("run finished", 1'b1, 1'b0);
		test_done();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rstn = 1'b0;
		f_inv = '0;
		bad_count = 0;
		samples_checked = 0;
		for (int k = 0; k < 9; k++) ev[k] = '0;
		for (int i = 0; i < NUM_PORTS; i++) begin
			f_dly[i] = 6'(i * 9 + 5);
			st1[i] = 8'(8'hA0 + i);
			st2[i] = 8'(8'h50 + i);
		end
		repeat (10) @(negedge clock);
		rstn = 1'b1;
		repeat (4) @(negedge clock);
		rdc("port select", ADDR_PORT_SEL, 8'h01);
		for (int a = 8'hD8; a <= 8'hDB; a++) rdc("reset value", 8'(a), 8'h00);
		rdc("filter status", ADDR_FILT_STS, {2'b00, f_dly[0]});
		wr(ADDR_EN_HI, 8'hFF);
		wr(ADDR_EN_LO, 8'hFF);
		wr(ADDR_PEND_HI, 8'hFF);
		rdc("enable hi", ADDR_EN_HI, 8'h07);
		rdc("enable lo", ADDR_EN_LO, 8'h77);
		rdc("pending hi", ADDR_PEND_HI, 8'h00);
		rdc("unmapped", 8'h10, 8'h00);
		wr(ADDR_EN_HI, 8'h00);
		wr(ADDR_EN_LO, 8'h00);
		rxpic_host_i.start();
		rxpic_host_i.xfer_out({7'h31, 1'b0}, ok);
		rxpic_host_i.stop();
		cmp1("foreign ack", 1'b0, ok);
		// Every event kind, dropped while disabled, then latched and cleared
		for (int k = 0; k < 9; k++) begin
			p = k % 4;
			er = EV_HI[k] ? ADDR_EN_HI : ADDR_EN_LO;
			pr = EV_HI[k] ? ADDR_PEND_HI : ADDR_PEND_LO;
			m = 8'h01 << EV_BIT[3*k +: 3];
			wr(ADDR_PORT_SEL, 8'(p * 16 + (1 << p)));
			pulse(k, 4'hF);
			cmp1("irq masked", 1'b0, irq_q);
			wr(er, m);
			pulse(k, 4'hF);
			cmp1("irq raised", 1'b1, irq_q);
			rdc("pending set", pr, m);
			rdc("other status", EV_TWO[k] ? ADDR_STS_ONE : ADDR_STS_TWO,
				EV_TWO[k] ? st1[p] : st2[p]);
			rdc("pending kept", pr, m);
			rdc("status", EV_TWO[k] ? ADDR_STS_TWO : ADDR_STS_ONE,
				EV_TWO[k] ? st2[p] : st1[p]);
			rdc("pending cleared", pr, 8'h00);
			cmp1("irq cleared", 1'b0, irq_q);
			wr(er, 8'h00);
		end
		// Copies of different ports stay apart
		wr(ADDR_PORT_SEL, 8'h0F);
		wr(ADDR_EN_LO, 8'h01);
		pulse(8, 4'h4);
		rdc("port 0 pending", ADDR_PEND_LO, 8'h00);
		wr(ADDR_PORT_SEL, 8'h2F);
		rdc("port 2 pending", ADDR_PEND_LO, 8'h01);
		rdc("port 2 status", ADDR_STS_ONE, st1[2]);
		cmp1("irq after clear", 1'b0, irq_q);
		// Filter error flag is sticky and clears when read
		@(negedge clock);
		f_inv = 4'h4;
		@(negedge clock);
		f_inv = 4'h0;
		rdc("filter error", ADDR_FILT_STS, {2'b01, f_dly[2]});
		rdc("filter cleared", ADDR_FILT_STS, {2'b00, f_dly[2]});
		// Burst write of both enables, burst read back with a host acknowledge
		rxpic_host_i.start();
		rxpic_host_i.xfer_out({7'h30, 1'b0}, ok);
		rxpic_host_i.xfer_out(ADDR_EN_HI, ok);
		rxpic_host_i.xfer_out(8'h05, ok);
		rxpic_host_i.xfer_out(8'h22, ok);
		rxpic_host_i.stop();
		cmp1("burst write ack", 1'b1, ok);
		rxpic_host_i.start();
		rxpic_host_i.xfer_out({7'h30, 1'b0}, ok);
		rxpic_host_i.xfer_out(ADDR_EN_HI, ok);
		rxpic_host_i.start();
		rxpic_host_i.xfer_out({7'h30, 1'b1}, ok);
		rxpic_host_i.xfer_in(1'b0, rv);
		cmp8("burst first", 8'h05, rv);
		rxpic_host_i.xfer_in(1'b1, rv);
		rxpic_host_i.stop();
		cmp8("burst second", 8'h22, rv);
		cmp1("irq burst", 1'b0, irq_q);
		test_done();
	end
endmodule : tb_rx_port_interrupt_control
